// ===== interrupt_vector_priority.sv
`timescale 1ns/1ps
module interrupt_vector_priority (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Special-register port
   input wire irq_pkg::sfr_bus_type sfrBus,
   output logic [7:0] sfrRdata,
   // Peripheral flags and hardware clears
   input wire irq_pkg::src_flags_type srcFlags,
   output logic [irq_pkg::NUM_HW_CLEAR-1:0] hwClear,
   // Core handshake
   input wire logic irqAck,
   input wire logic irqReturn,
   output logic irqReq,
   output logic [15:0] irqVector,
   output logic irqHighLevel
);
   import irq_pkg::*;

   // Software-visible control registers
   logic [7:0] irqEnableMain;
   logic [7:0] irqEnableExt1;
   logic [7:0] irqEnableExt2;
   logic [7:0] irqPriorityMain;
   logic [7:0] irqPriorityExt1;
   logic [7:0] irqPriorityExt2;

   // Per-source enable and level vectors
   logic [NUM_SRC-1:0] enables;
   logic [NUM_SRC-1:0] prioHigh;
   logic [NUM_SRC-1:0] reqHigh;
   logic [NUM_SRC-1:0] reqLow;

   // Picker results
   logic highFound;
   logic lowFound;
   logic [IDX_W-1:0] highIdx;
   logic [IDX_W-1:0] lowIdx;

   // Winner after in-service masking
   logic winValid;
   logic winHigh;
   logic [IDX_W-1:0] winIdx;

   // Offer and service state
   ctrl_state_type state;
   logic [IDX_W-1:0] offeredIdx;
   logic inSvcHigh;
   logic inSvcLow;
   logic accept;
   logic [7:0] statusWord;

   // Register write strobes
   logic wrEnableMain;
   logic wrEnableExt1;
   logic wrEnableExt2;
   logic wrPrioMain;
   logic wrPrioExt1;
   logic wrPrioExt2;

   // Write strobe for one register address
   function automatic logic wr_hit(input sfr_bus_type b, input logic [7:0] a);
      wr_hit = b.write && (b.addr == a);
   endfunction

   // Address decode of writes
   always_comb begin
      wrEnableMain = wr_hit(sfrBus, ADDR_ENABLE_MAIN);
      wrEnableExt1 = wr_hit(sfrBus, ADDR_ENABLE_EXT1);
      wrEnableExt2 = wr_hit(sfrBus, ADDR_ENABLE_EXT2);
      wrPrioMain = wr_hit(sfrBus, ADDR_PRIO_MAIN);
      wrPrioExt1 = wr_hit(sfrBus, ADDR_PRIO_EXT1);
      wrPrioExt2 = wr_hit(sfrBus, ADDR_PRIO_EXT2);
   end

   // Main enable register
   always_ff @(posedge clk) begin
      if (rst) begin
         irqEnableMain <= REG_ZERO;
      end else if (wrEnableMain) begin
         irqEnableMain <= sfrBus.wdata;
      end
   end

   // Extended enable registers, unused bits stay zero
   always_ff @(posedge clk) begin
      if (rst) begin
         irqEnableExt1 <= REG_ZERO;
         irqEnableExt2 <= REG_ZERO;
      end else begin
         if (wrEnableExt1) begin
            irqEnableExt1 <= sfrBus.wdata & EXT1_MASK;
         end
         if (wrEnableExt2) begin
            irqEnableExt2 <= sfrBus.wdata & EXT2_MASK;
         end
      end
   end

   // Main priority register, top bit fixed at one
   always_ff @(posedge clk) begin
      if (rst) begin
         irqPriorityMain <= PRIO_MAIN_RESET;
      end else if (wrPrioMain) begin
         irqPriorityMain <= (sfrBus.wdata & PRIO_MAIN_MASK) | PRIO_MAIN_FIXED;
      end
   end

   // Extended priority registers, reserved bits read as zero
   always_ff @(posedge clk) begin
      if (rst) begin
         irqPriorityExt1 <= REG_ZERO;
         irqPriorityExt2 <= REG_ZERO;
      end else begin
         if (wrPrioExt1) begin
            irqPriorityExt1 <= sfrBus.wdata & EXT1_MASK;
         end
         if (wrPrioExt2) begin
            irqPriorityExt2 <= sfrBus.wdata & EXT2_MASK;
         end
      end
   end

   // Register bits onto natural orders, same layout for enable and level
   function automatic logic [NUM_SRC-1:0] order_map(input logic [7:0] m, input logic [7:0] e1,
      input logic [7:0] e2);
      order_map = '0;
      order_map[NUM_MAIN_SRC-1:0] = m[NUM_MAIN_SRC-1:0];
      order_map[ORDER_RESERVED-1:NUM_MAIN_SRC] = e1[EXT1_LOW_BITS-1:0];
      order_map[ORDER_RESERVED+1] = e1[EXT1_TIMER3_BIT];
      order_map[NUM_SRC-1:NUM_SRC-EXT2_BITS] = e2[EXT2_BITS-1:0];
   endfunction

   // Register bits mapped onto natural orders
   always_comb begin
      enables = order_map(irqEnableMain, irqEnableExt1, irqEnableExt2);
      prioHigh = order_map(irqPriorityMain, irqPriorityExt1, irqPriorityExt2);
   end

   // Flag folding and gating
   irq_source_gate gate (
      .flags(srcFlags),
      .enables(enables),
      .prioHigh(prioHigh),
      .reqHigh(reqHigh),
      .reqLow(reqLow)
   );

   // High level picker
   irq_priority_pick pickHigh (
      .req(reqHigh),
      .found(highFound),
      .idx(highIdx)
   );

   // Low level picker
   irq_priority_pick pickLow (
      .req(reqLow),
      .found(lowFound),
      .idx(lowIdx)
   );

   // High may preempt low service; nothing preempts high service
   always_comb begin
      winValid = 1'b0;
      winHigh = 1'b0;
      winIdx = highIdx;
      if (highFound && !inSvcHigh) begin
         winValid = 1'b1;
         winHigh = 1'b1;
      end else if (lowFound && !inSvcHigh && !inSvcLow) begin
         winValid = 1'b1;
         winIdx = lowIdx;
      end
   end

   // Core takes the offer shown this cycle
   always_comb begin
      accept = (state == ST_OFFER) && irqAck;
   end

   // Offer sequencing toward the core
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
         irqReq <= 1'b0;
         irqVector <= RESET_VECTOR;
         irqHighLevel <= 1'b0;
         offeredIdx <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (winValid) begin
                  irqReq <= 1'b1;
                  irqVector <= vector_of(winIdx);
                  irqHighLevel <= winHigh;
                  offeredIdx <= winIdx;
                  state <= ST_OFFER;
               end
            end
            ST_OFFER: begin
               if (irqAck) begin
                  irqReq <= 1'b0;
                  state <= ST_SETTLE;
               end else if (winValid) begin
                  irqVector <= vector_of(winIdx);
                  irqHighLevel <= winHigh;
                  offeredIdx <= winIdx;
               end else begin
                  irqReq <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            ST_SETTLE: begin
               // One idle cycle lets the cleared flag drop
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // High in-service, set on a high accept, unwound first on return
   always_ff @(posedge clk) begin
      if (rst) begin
         inSvcHigh <= 1'b0;
      end else if (accept) begin
         if (irqHighLevel) begin
            inSvcHigh <= 1'b1;
         end
      end else if (irqReturn) begin
         inSvcHigh <= 1'b0;
      end
   end

   // Low in-service, unwound on return only when no high routine runs
   always_ff @(posedge clk) begin
      if (rst) begin
         inSvcLow <= 1'b0;
      end else if (accept) begin
         if (!irqHighLevel) begin
            inSvcLow <= 1'b1;
         end
      end else if (irqReturn && !inSvcHigh) begin
         inSvcLow <= 1'b0;
      end
   end

   // Clear pulse only for the hardware-cleared orders
   always_ff @(posedge clk) begin
      if (rst) begin
         hwClear <= '0;
      end else begin
         for (int i = 0; i < NUM_HW_CLEAR; i++) begin
            hwClear[i] <= accept && (offeredIdx == IDX_W'(i));
         end
      end
   end

   // Status byte: in-service levels, offer flag, offered order
   always_comb begin
      statusWord = {inSvcHigh, inSvcLow, irqReq, offeredIdx};
   end

   // Read data, answered one cycle after the read strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         sfrRdata <= REG_ZERO;
      end else if (sfrBus.read) begin
         unique case (sfrBus.addr)
            ADDR_ENABLE_MAIN: sfrRdata <= irqEnableMain;
            ADDR_ENABLE_EXT1: sfrRdata <= irqEnableExt1;
            ADDR_ENABLE_EXT2: sfrRdata <= irqEnableExt2;
            ADDR_PRIO_MAIN: sfrRdata <= irqPriorityMain | PRIO_MAIN_FIXED;
            ADDR_PRIO_EXT1: sfrRdata <= irqPriorityExt1;
            ADDR_PRIO_EXT2: sfrRdata <= irqPriorityExt2 & EXT2_MASK;
            ADDR_IRQ_STATUS: sfrRdata <= statusWord;
            default: sfrRdata <= REG_ZERO;
         endcase
      end
   end

endmodule

// ===== irq_pkg.sv
package irq_pkg;

   // Source slots: natural orders 0 to 16, order 13 is unused
   localparam int NUM_SRC = 17;
   localparam int IDX_W = 5;
   localparam int NUM_MAIN_SRC = 7;
   localparam int NUM_HW_CLEAR = 4;
   localparam int ORDER_RESERVED = 13;
   localparam int PCA_MODULES = 3;

   // Register addresses on the special-register port
   localparam logic [7:0] ADDR_PRIO_MAIN = 8'hB8;
   localparam logic [7:0] ADDR_PRIO_EXT2 = 8'hCF;
   localparam logic [7:0] ADDR_ENABLE_MAIN = 8'hA8;
   localparam logic [7:0] ADDR_ENABLE_EXT1 = 8'hE6;
   localparam logic [7:0] ADDR_ENABLE_EXT2 = 8'hE7;
   localparam logic [7:0] ADDR_PRIO_EXT1 = 8'hF6;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hF7;

   // Reset values and masks
   localparam logic [7:0] PRIO_MAIN_RESET = 8'h80;
   localparam logic [7:0] PRIO_MAIN_FIXED = 8'h80;
   localparam logic [7:0] PRIO_MAIN_MASK = 8'h7F;
   localparam logic [7:0] EXT1_MASK = 8'hBF;
   localparam logic [7:0] EXT2_MASK = 8'h03;
   localparam logic [7:0] REG_ZERO = 8'h00;

   // Field positions inside the extended registers
   localparam int EXT1_LOW_BITS = 6;
   localparam int EXT1_TIMER3_BIT = 7;
   localparam int EXT2_BITS = 2;

   // Vector table
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_STRIDE = 16'h0008;

   // Special-register port request
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_bus_type;

   // Pending flags as held by the peripherals
   typedef struct packed {
      logic ext0_pending;
      logic timer0_ovf_flag;
      logic ext1_pending;
      logic timer1_ovf_flag;
      logic uart_rx_flag;
      logic uart_tx_flag;
      logic timer2_high_ovf;
      logic timer2_low_ovf;
      logic spi_done_flag;
      logic spi_write_collision;
      logic spi_mode_fault;
      logic spi_rx_overrun;
      logic smbus_flag;
      logic portmatch_level;
      logic adc_window_flag;
      logic adc_done_flag;
      logic pca_counter_ovf;
      logic [PCA_MODULES-1:0] pca_module_flag;
      logic comp_fall_flag;
      logic comp_rise_flag;
      logic timer3_high_ovf;
      logic timer3_low_ovf;
      logic capsense_done_flag;
      logic capsense_cmp_flag;
   } src_flags_type;

   typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_SETTLE} ctrl_state_type;

   // Vector address of a source by natural order
   function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
      vector_of = VEC_BASE + VEC_STRIDE * 16'(idx);
   endfunction

endpackage

// ===== irq_source_gate.sv
`timescale 1ns/1ps
module irq_source_gate (
   // Peripheral flags
   input wire irq_pkg::src_flags_type flags,
   // Per-source enable and level
   input wire logic [irq_pkg::NUM_SRC-1:0] enables,
   input wire logic [irq_pkg::NUM_SRC-1:0] prioHigh,
   // Gated requests per level
   output logic [irq_pkg::NUM_SRC-1:0] reqHigh,
   output logic [irq_pkg::NUM_SRC-1:0] reqLow
);
   import irq_pkg::*;

   logic [NUM_SRC-1:0] pending;

   // Fold each source's flags into one pending bit per order
   always_comb begin
      pending = '0;
      pending[0] = flags.ext0_pending;
      pending[1] = flags.timer0_ovf_flag;
      pending[2] = flags.ext1_pending;
      pending[3] = flags.timer1_ovf_flag;
      pending[4] = flags.uart_rx_flag | flags.uart_tx_flag;
      pending[5] = flags.timer2_high_ovf | flags.timer2_low_ovf;
      pending[6] = flags.spi_done_flag | flags.spi_write_collision
         | flags.spi_mode_fault | flags.spi_rx_overrun;
      pending[7] = flags.smbus_flag;
      pending[8] = flags.portmatch_level;
      pending[9] = flags.adc_window_flag;
      pending[10] = flags.adc_done_flag;
      pending[11] = flags.pca_counter_ovf | (|flags.pca_module_flag);
      pending[12] = flags.comp_fall_flag | flags.comp_rise_flag;
      pending[ORDER_RESERVED] = 1'b0;
      pending[14] = flags.timer3_high_ovf | flags.timer3_low_ovf;
      pending[15] = flags.capsense_done_flag;
      pending[16] = flags.capsense_cmp_flag;
   end

   // Enable gates, priority bit picks the level
   always_comb begin
      reqHigh = pending & enables & prioHigh;
      reqLow = pending & enables & ~prioHigh;
   end

endmodule

// ===== irq_priority_pick.sv
`timescale 1ns/1ps
module irq_priority_pick (
   // Requests of one level
   input wire logic [irq_pkg::NUM_SRC-1:0] req,
   // Winner
   output logic found,
   output logic [irq_pkg::IDX_W-1:0] idx
);
   import irq_pkg::*;

   // Lowest natural order wins
   function automatic logic [IDX_W-1:0] lowest_set(input logic [NUM_SRC-1:0] r);
      lowest_set = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (r[i]) begin
            lowest_set = IDX_W'(i);
         end
      end
   endfunction

   // Pick result
   always_comb begin
      found = |req;
      idx = lowest_set(req);
   end

endmodule

// ===== irq_checker.sv
`timescale 1ns/1ps
module irq_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Observed ports
   input wire irq_pkg::sfr_bus_type sfrBus,
   input wire logic [7:0] sfrRdata,
   input wire logic [irq_pkg::NUM_HW_CLEAR-1:0] hwClear,
   input wire logic irqAck,
   input wire logic irqReq,
   input wire logic [15:0] irqVector,
   input wire logic irqHighLevel
);
   import irq_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Core takes the offer, then one clear pulse
   sequence take_s;
      irqReq && irqAck;
   endsequence
   sequence clear_s(logic [3:0] m);
      hwClear == m ##1 hwClear == 4'h0;
   endsequence
   property hw_clr_p(logic [15:0] v, logic [3:0] m);
      take_s ##0 irqVector == v |=> clear_s(m);
   endproperty
   // Outputs at the first edge after reset
   reset_out_a: assert property ($fell(rst) |-> !irqReq && irqVector == 16'h0000 &&
      !irqHighLevel && hwClear == 4'h0) else $error("outputs not idle after reset");
   take_drop_a: assert property (take_s |=> !irqReq)
      else $error("offer stands after accept");
   ext0_clear_a: assert property (hw_clr_p(16'h0003, 4'h1))
      else $error("ext0 clear missing");
   timer0_clear_a: assert property (hw_clr_p(16'h000B, 4'h2))
      else $error("timer0 clear missing");
   ext1_clear_a: assert property (hw_clr_p(16'h0013, 4'h4))
      else $error("ext1 clear missing");
   timer1_clear_a: assert property (hw_clr_p(16'h001B, 4'h8))
      else $error("timer1 clear missing");
   soft_noclear_a: assert property (take_s ##0 irqVector > 16'h001B |=> hwClear == 4'h0)
      else $error("hardware clear on software source");
   vector_form_a: assert property (irqReq |-> irqVector[2:0] == 3'h3 &&
      irqVector <= 16'h0083 && irqVector != 16'h006B) else $error("bad vector");
   prio_bit7_a: assert property (sfrBus.read && sfrBus.addr == 8'hB8 |=> sfrRdata[7])
      else $error("priority bit 7 not one");
   ext2_zero_a: assert property (sfrBus.read && sfrBus.addr == 8'hCF |=>
      sfrRdata[7:2] == 6'h00) else $error("reserved bits not zero");
   clear_cause_a: assert property (hwClear != 4'h0 |-> $past(irqReq && irqAck))
      else $error("clear without accept");
endmodule
bind interrupt_vector_priority irq_checker irq_checker_i (.clk(clk), .rst(rst), .sfrBus(sfrBus),
   .sfrRdata(sfrRdata), .hwClear(hwClear), .irqAck(irqAck), .irqReq(irqReq),
   .irqVector(irqVector), .irqHighLevel(irqHighLevel));

// ===== flag_source_model.sv
`timescale 1ns/1ps
module flag_source_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bench set and software clear, top bit is ext0
   input wire logic [$bits(irq_pkg::src_flags_type)-1:0] setMask,
   input wire logic [$bits(irq_pkg::src_flags_type)-1:0] clrMask,
   // Hardware clears from the controller
   input wire logic [irq_pkg::NUM_HW_CLEAR-1:0] hwClear,
   output irq_pkg::src_flags_type srcFlags
);
   import irq_pkg::*;
   localparam int FW = $bits(src_flags_type);
   logic [FW-1:0] flags;
   logic [FW-1:0] hwMask;
   // Clear pulse bit i drops the flag of order i
   assign hwMask = {hwClear[0], hwClear[1], hwClear[2], hwClear[3], (FW-4)'(0)};
   // Flags latch until cleared by software or hardware
   always_ff @(posedge clk) begin
      if (rst) begin
         flags <= '0;
      end else begin
         flags <= (flags | setMask) & ~clrMask & ~hwMask;
      end
   end
   assign srcFlags = flags;
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import irq_pkg::*;
   localparam int FW = $bits(src_flags_type);
   // Flag position from the top bit by order, first and last flag
   localparam int POS_A [17] = '{0, 1, 2, 3, 4, 6, 8, 12, 13, 14, 15, 16, 20, 0, 22, 24, 25};
   localparam int POS_B [17] = '{0, 1, 2, 3, 5, 7, 11, 12, 13, 14, 15, 19, 21, 0, 23, 24, 25};
   logic clk = 1'b0;
   logic rst = 1'b1;
   sfr_bus_type sfrBus = '0;
   logic [7:0] sfrRdata;
   src_flags_type srcFlags;
   logic [NUM_HW_CLEAR-1:0] hwClear;
   logic [NUM_HW_CLEAR-1:0] seenClear;
   logic irqAck = 1'b0;
   logic irqReturn = 1'b0;
   logic irqReq;
   logic [15:0] irqVector;
   logic irqHighLevel;
   logic [FW-1:0] setMask = '0;
   logic [FW-1:0] clrMask = '0;
   int miscompares = 0;
   int check_count = 0;
   // Clock at 100 ns period
   always #50 clk = ~clk;
   interrupt_vector_priority interrupt_vector_priority_i (.clk(clk), .rst(rst), .sfrBus(sfrBus),
      .sfrRdata(sfrRdata), .srcFlags(srcFlags), .hwClear(hwClear), .irqAck(irqAck),
      .irqReturn(irqReturn), .irqReq(irqReq), .irqVector(irqVector),
      .irqHighLevel(irqHighLevel));
   flag_source_model flag_source_model_i (.clk(clk), .rst(rst), .setMask(setMask),
      .clrMask(clrMask), .hwClear(hwClear), .srcFlags(srcFlags));
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One cycle of stimulus, then one idle cycle
   task automatic step(input sfr_bus_type b, input logic [FW-1:0] s, input logic [FW-1:0] c,
      input logic a, input logic r);
      sfrBus = b;
      setMask = s;
      clrMask = c;
      irqAck = a;
      irqReturn = r;
      @(posedge clk);
      #1;
      seenClear = hwClear;
      sfrBus = '0;
      setMask = '0;
      clrMask = '0;
      irqAck = 1'b0;
      irqReturn = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      step({1'b1, 1'b0, a, d}, '0, '0, 1'b0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      step({1'b0, 1'b1, a, 8'h00}, '0, '0, 1'b0, 1'b0);
      check($sformatf("reg %h", a), 16'(sfrRdata), 16'(e));
   endtask
   task automatic no_req();
      repeat (4) @(posedge clk);
      #1;
      check("no offer", 16'(irqReq), 16'h0000);
   endtask
   // Bounded wait for an offer, then vector and level
   task automatic wait_req(input logic [15:0] v, input logic hi);
      int n;
      n = 0;
      while (irqReq !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("offer", 16'(irqReq), 16'h0001);
      check("vector", irqVector, v);
      check("level", 16'(irqHighLevel), 16'(hi));
      if (irqReq !== 1'b1) begin
         close_out();
      end
   endtask
   function automatic logic [FW-1:0] fm(input int pos);
      fm = FW'(1) << (FW - 1 - pos);
   endfunction
   function automatic logic [7:0] bm(input int o);
      bm = 8'(1) << (o < 7 ? o : (o == 14 ? 7 : (o < 15 ? o - 7 : o - 15)));
   endfunction
   // Main sequence
   initial begin
      logic [FW-1:0] f;
      logic [7:0] ea;
      logic [7:0] pa;
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      check("vector at reset", irqVector, 16'h0000);
      rd(ADDR_PRIO_MAIN, 8'h80);
      rd(ADDR_PRIO_EXT2, 8'h00);
      rd(ADDR_ENABLE_MAIN, 8'h00);
      rd(8'h12, 8'h00);
      wr(ADDR_PRIO_MAIN, 8'h00);
      rd(ADDR_PRIO_MAIN, 8'h80);
      wr(ADDR_PRIO_EXT2, 8'h03);
      rd(ADDR_PRIO_EXT2, 8'h03);
      wr(ADDR_ENABLE_EXT1, 8'hFF);
      rd(ADDR_ENABLE_EXT1, 8'hBF);
      wr(ADDR_ENABLE_EXT1, 8'h00);
      wr(ADDR_ENABLE_EXT2, 8'hFF);
      rd(ADDR_ENABLE_EXT2, 8'h03);
      wr(ADDR_ENABLE_EXT2, 8'h00);
      wr(ADDR_PRIO_EXT1, 8'hFF);
      rd(ADDR_PRIO_EXT1, 8'hBF);
      $display("test registers done");
      // Every source on both levels, last flag of shared sources on pass 1
      for (int p = 0; p < 2; p++) begin
         for (int o = 0; o < NUM_SRC; o++) begin
            if (o == ORDER_RESERVED) continue;
            f = fm(p == 0 ? POS_A[o] : POS_B[o]);
            ea = o < 7 ? ADDR_ENABLE_MAIN : (o < 15 ? ADDR_ENABLE_EXT1 : ADDR_ENABLE_EXT2);
            pa = o < 7 ? ADDR_PRIO_MAIN : (o < 15 ? ADDR_PRIO_EXT1 : ADDR_PRIO_EXT2);
            step('0, f, '0, 1'b0, 1'b0);
            no_req();
            wr(pa, p == 1 ? bm(o) : 8'h00);
            wr(ea, bm(o));
            wait_req(16'h0003 + 16'(8 * o), p == 1);
            step('0, '0, '0, 1'b1, 1'b0);
            check("clear", 16'(seenClear), o < 4 ? 16'(1 << o) : 16'h0000);
            step('0, '0, f, 1'b0, 1'b0);
            wr(ea, 8'h00);
            step('0, '0, '0, 1'b0, 1'b1);
            no_req();
         end
      end
      $display("test vectors done");
      // Tie at one level, refusal in service, high preempts low
      wr(ADDR_ENABLE_MAIN, 8'h7F);
      wr(ADDR_PRIO_MAIN, 8'h40);
      step('0, fm(1) | fm(4), '0, 1'b0, 1'b0);
      wait_req(16'h000B, 1'b0);
      step('0, '0, '0, 1'b1, 1'b0);
      no_req();
      step('0, fm(8), '0, 1'b0, 1'b0);
      wait_req(16'h0033, 1'b1);
      rd(ADDR_IRQ_STATUS, 8'h66);
      step('0, '0, fm(8), 1'b1, 1'b0);
      step('0, '0, '0, 1'b0, 1'b1);
      no_req();
      step('0, '0, '0, 1'b0, 1'b1);
      wait_req(16'h0023, 1'b0);
      step('0, '0, fm(4), 1'b1, 1'b0);
      step('0, '0, '0, 1'b0, 1'b1);
      no_req();
      $display("test priority done");
      close_out();
   end
endmodule
